// ---- inc/csb_cfg.svh ----
// Constants of the channel status buffer: register indices, fields, resets, counts.
// Assumes inclusion by bare name from the package and the design files.
// Operation
// RULE1: Ten channel status bytes, five for each subframe channel, are held for the host.
// RULE2: Incoming bits fill a capture buffer, and only whole blocks are copied to the host buffer.
// RULE3: The earliest received bit of each byte lands in its top bit, so byte 0 bit 7 is the pro flag.
// RULE4: The host buffer sits in the register map and reads return its ten bytes.
// RULE5: The whole stream leaves serially on a dedicated or general pin, on both frame clock edges.
// RULE6: With error gating off, only loss of receiver lock blocks a transfer.
// RULE7: With error gating on, biphase, confidence, parity or CRC errors also block a transfer.
// RULE8: Each transfer raises an interrupt when its enable is set.
// RULE9: A transfer-inhibit bit in the receiver data control register suppresses copying.
// RULE10: Transfers are spaced by about one block of frames so the host can read in between.
// RULE11: The host reads and interprets the copy management fields itself.
// RULE12: The host reads soon after a transfer interrupt and inhibits around long accesses.
// RULE13: The error gating control is bit 7 of the receiver status register and resets to 0.
// RULE14: All ten bytes are copied in one cycle so a read never mixes two blocks.
`ifndef CSB_CFG_SVH
`define CSB_CFG_SVH

// ==========================================================
// Register indices (byte address is four times the index)
`define CSB_IDX_RX_DATA_CTRL 6'h04
`define CSB_IDX_RX_STATUS    6'h16
`define CSB_IDX_CS_FIRST     6'h23
`define CSB_IDX_CS_LAST      6'h2c
`define CSB_IDX_IRQ_STATUS   6'h31
`define CSB_IDX_IRQ_MASK     6'h32

// ==========================================================
// Field positions and reset values
`define CSB_CTRL_INHIBIT_BIT 0
`define CSB_CTRL_CLKSEL_BIT  1
`define CSB_STAT_UPDATE_BIT  7
`define CSB_STAT_LOCK_BIT    4
`define CSB_STAT_UPDATE_RST  1'b0
`define CSB_IRQ_XFER_BIT     0
`define CSB_IRQ_BLOCKED_BIT  1
`define CSB_IRQ_W            2

// ==========================================================
// Counts
`define CSB_STORED_BYTES     5
`define CSB_STORED_BITS      40
`define CSB_BLOCK_FRAMES     192
`define CSB_MIN_GAP_FRAMES   192

`endif

// ---- inc/csb_pkg.sv ----
// Types shared by the channel status buffer modules.
// Assumes csb_cfg.svh on the include path.
`include "csb_cfg.svh"

package csb_pkg;

  // Receiver channel status bit stream; block_start never coincides with valid
  typedef struct packed {
    logic valid;
    logic chan;
    logic cbit;
    logic block_start;
  } csb_rx_t;

  typedef struct packed {
    logic crc;
    logic conf;
    logic biphase;
    logic parity;
  } csb_err_t;

  typedef enum logic [1:0] {
    CSB_BUS_IDLE = 2'b00,
    CSB_BUS_ACK  = 2'b01
  } csb_bus_st_t;

endpackage

// ---- rtl/csb_serout.sv ----
// Serial channel status output, one bit per frame clock edge.
// Assumes frame clocks synchronous to clk and slower than half its rate.
`timescale 1ns/1ps
`default_nettype none

module csb_serout
  import csb_pkg::*;
(
  input  wire logic    clk,
  input  wire logic    srst,
  input  wire csb_rx_t rx_in,
  input  wire logic    hw_mode,
  input  wire logic    clk_sel,
  input  wire logic    output_frame_clock,
  input  wire logic    auxiliary_frame_clock,
  output logic         cs_serial_pin,
  output logic         general_output_pin
);

  logic fc;
  logic fc_prev_r;
  logic pend_a_r;
  logic pend_b_r;
  logic out_r;

  assign fc = clk_sel ? auxiliary_frame_clock : output_frame_clock;

  always_ff @(posedge clk) begin
    if (srst) begin
      pend_a_r <= 1'b0;
      pend_b_r <= 1'b0;
    end else if (rx_in.valid) begin
      if (rx_in.chan) begin
        pend_b_r <= rx_in.cbit;
      end else begin
        pend_a_r <= rx_in.cbit;
      end
    end
  end

  // Rising edge carries channel A, falling edge channel B
  always_ff @(posedge clk) begin
    if (srst) begin
      fc_prev_r <= 1'b0;
      out_r     <= 1'b0;
    end else begin
      fc_prev_r <= fc;
      if (fc && !fc_prev_r) begin
        out_r <= pend_a_r; // RULE5
      end else if (!fc && fc_prev_r) begin
        out_r <= pend_b_r; // RULE5
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cs_serial_pin      <= 1'b0;
      general_output_pin <= 1'b0;
    end else begin
      cs_serial_pin      <= hw_mode ? out_r : 1'b0; // RULE5
      general_output_pin <= hw_mode ? 1'b0 : out_r; // RULE5
    end
  end

  serial_edge_a: assert property (@(posedge clk) disable iff (srst) // RULE5
    (fc && !fc_prev_r) |=> (out_r == $past(pend_a_r)) ##1 (hw_mode || general_output_pin == $past(out_r)))
    else $error("serial bit not shifted on frame clock edge");

endmodule

`default_nettype wire

// ---- rtl/csb_top.sv ----
// Channel status capture and host buffer with Avalon-MM register slave.
// Assumes a receiver that delivers one channel status bit per subframe and a block start pulse.
`timescale 1ns/1ps
`default_nettype none

`include "csb_cfg.svh"

module csb_top
  import csb_pkg::*;
#(
  parameter int BLOCK_FRAMES   = `CSB_BLOCK_FRAMES,
  parameter int MIN_GAP_FRAMES = `CSB_MIN_GAP_FRAMES
) (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire csb_rx_t     rx_in,
  input  wire csb_err_t    rx_err,
  input  wire logic        rx_pll_lock,
  input  wire logic        hw_mode,
  input  wire logic        output_frame_clock,
  input  wire logic        auxiliary_frame_clock,
  output logic             cs_serial_pin,
  output logic             general_output_pin,
  output logic             irq
);

  localparam int NB = `CSB_STORED_BYTES;

  // ==========================================================
  // Storage
  logic [7:0] cap_r  [2][NB];
  logic [7:0] host_r [2][NB];
  logic [7:0] bit_idx_r [2];
  logic [7:0] frame_cnt_r;
  logic [7:0] gap_cnt_r;
  logic [3:0] err_acc_r;
  logic [3:0] blk_err_r;
  logic       lock_lost_r;

  // ==========================================================
  // Registers
  logic                     inhibit_r;
  logic                     clk_sel_r;
  logic                     cs_update_r;
  logic [`CSB_IRQ_W-1:0]    irq_stat_r;
  logic [`CSB_IRQ_W-1:0]    irq_mask_r;
  csb_bus_st_t              bus_st_r;

  logic                     blk_full;
  logic                     gap_ok;
  logic                     lock_ok;
  logic                     gate_ok;
  logic                     xfer;
  logic                     blocked;
  logic [5:0]               reg_idx;
  logic                     req;
  logic                     wr_commit;
  logic [`CSB_IRQ_W-1:0]    irq_set;
  logic [`CSB_IRQ_W-1:0]    irq_clr;

  function automatic logic [7:0] sat_inc(input logic [7:0] v);
    sat_inc = (v == 8'hff) ? v : v + 8'h01;
  endfunction

  function automatic logic is_cs_idx(input logic [5:0] idx);
    is_cs_idx = (idx >= `CSB_IDX_CS_FIRST) && (idx <= `CSB_IDX_CS_LAST);
  endfunction

  // ==========================================================
  // Transfer decision
  assign blk_full = frame_cnt_r >= 8'(BLOCK_FRAMES);                     // RULE2
  assign gap_ok   = gap_cnt_r >= 8'(MIN_GAP_FRAMES);                     // RULE10
  assign lock_ok  = rx_pll_lock && !lock_lost_r;                         // RULE6
  assign gate_ok  = lock_ok && (!cs_update_r || (err_acc_r == 4'h0));    // RULE7
  assign xfer     = rx_in.block_start && blk_full && gap_ok && gate_ok && !inhibit_r; // RULE9
  assign blocked  = rx_in.block_start && blk_full && !xfer;

  // ==========================================================
  // Capture buffer: first 40 bits of each channel, earliest bit in the MSB
  // Bits past the fortieth still reach the serial pin; only storage stops
  always_ff @(posedge clk) begin
    if (srst) begin
      for (int c = 0; c < 2; c++) begin
        bit_idx_r[c] <= 8'h00;
        for (int b = 0; b < NB; b++) begin
          cap_r[c][b] <= 8'h00;
        end
      end
    end else if (rx_in.block_start) begin
      bit_idx_r[0] <= 8'h00;
      bit_idx_r[1] <= 8'h00;
    end else if (rx_in.valid) begin
      if (bit_idx_r[rx_in.chan] < 8'(`CSB_STORED_BITS)) begin
        cap_r[rx_in.chan][bit_idx_r[rx_in.chan][5:3]][3'd7 - bit_idx_r[rx_in.chan][2:0]]
          <= rx_in.cbit; // RULE3
      end
      bit_idx_r[rx_in.chan] <= sat_inc(bit_idx_r[rx_in.chan]); // RULE1
    end
  end

  // Frames counted on channel B bits; saturating so a stalled stream never wraps
  always_ff @(posedge clk) begin
    if (srst) begin
      frame_cnt_r <= 8'h00;
      gap_cnt_r   <= 8'(MIN_GAP_FRAMES);
    end else begin
      if (rx_in.block_start) begin
        frame_cnt_r <= 8'h00;
      end else if (rx_in.valid && rx_in.chan) begin
        frame_cnt_r <= sat_inc(frame_cnt_r);
      end
      if (xfer) begin
        gap_cnt_r <= 8'h00; // RULE10
      end else if (rx_in.valid && rx_in.chan) begin
        gap_cnt_r <= sat_inc(gap_cnt_r);
      end
    end
  end

  // Errors and lock loss gathered over the block, restarted at its boundary
  // Lock is judged over the whole block, so a brief slip still blocks the copy
  always_ff @(posedge clk) begin
    if (srst) begin
      err_acc_r   <= 4'h0;
      blk_err_r   <= 4'h0;
      lock_lost_r <= 1'b0;
    end else if (rx_in.block_start) begin
      blk_err_r   <= err_acc_r;
      err_acc_r   <= rx_err;
      lock_lost_r <= !rx_pll_lock;
    end else begin
      err_acc_r   <= err_acc_r | rx_err;           // RULE7
      lock_lost_r <= lock_lost_r | !rx_pll_lock;   // RULE6
    end
  end

  // Host buffer: all ten bytes in a single cycle
  // A host read can never see half of one block and half of the next
  always_ff @(posedge clk) begin
    if (srst) begin
      for (int c = 0; c < 2; c++) begin
        for (int b = 0; b < NB; b++) begin
          host_r[c][b] <= 8'h00;
        end
      end
    end else if (xfer) begin
      host_r <= cap_r; // RULE14
    end
  end

  // ==========================================================
  // Avalon-MM slave: one wait cycle on every access
  // Read data is registered: one clock of latency traded for a short decode path
  assign reg_idx   = avs_address[7:2];
  assign req       = avs_read || avs_write;
  assign wr_commit = (bus_st_r == CSB_BUS_ACK) && avs_write && avs_byteenable[0]
                     && (avs_address[1:0] == 2'b00);

  function automatic logic [7:0] rd_value(input logic [5:0] idx);
    logic [5:0] k;
    k = idx - `CSB_IDX_CS_FIRST;
    rd_value = 8'h00;
    if (idx == `CSB_IDX_RX_DATA_CTRL) begin
      rd_value = {6'h00, clk_sel_r, inhibit_r};
    end else if (idx == `CSB_IDX_RX_STATUS) begin
      rd_value = {cs_update_r, 2'b00, rx_pll_lock, blk_err_r};
    end else if (is_cs_idx(idx)) begin
      rd_value = (k < 6'(NB)) ? host_r[0][k[2:0]] : host_r[1][3'(k - 6'(NB))]; // RULE4
    end else if (idx == `CSB_IDX_IRQ_STATUS) begin
      rd_value = {6'h00, irq_stat_r};
    end else if (idx == `CSB_IDX_IRQ_MASK) begin
      rd_value = {6'h00, irq_mask_r};
    end
  endfunction

  always_ff @(posedge clk) begin
    if (srst) begin
      bus_st_r        <= CSB_BUS_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else begin
      case (bus_st_r)
        CSB_BUS_IDLE: begin
          if (req) begin
            bus_st_r        <= CSB_BUS_ACK;
            avs_waitrequest <= 1'b0;
            avs_readdata    <= (avs_read && avs_address[1:0] == 2'b00)
                               ? {24'h000000, rd_value(reg_idx)} : 32'h0000_0000;
          end
        end
        CSB_BUS_ACK: begin
          bus_st_r        <= CSB_BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
        default: begin
          bus_st_r        <= CSB_BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      inhibit_r   <= 1'b0;
      clk_sel_r   <= 1'b0;
      cs_update_r <= `CSB_STAT_UPDATE_RST; // RULE13
      irq_mask_r  <= '0;
    end else if (wr_commit) begin
      if (reg_idx == `CSB_IDX_RX_DATA_CTRL) begin
        inhibit_r <= avs_writedata[`CSB_CTRL_INHIBIT_BIT]; // RULE9
        clk_sel_r <= avs_writedata[`CSB_CTRL_CLKSEL_BIT];
      end else if (reg_idx == `CSB_IDX_RX_STATUS) begin
        cs_update_r <= avs_writedata[`CSB_STAT_UPDATE_BIT]; // RULE13
      end else if (reg_idx == `CSB_IDX_IRQ_MASK) begin
        irq_mask_r <= avs_writedata[`CSB_IRQ_W-1:0];
      end
    end
  end

  // ==========================================================
  // Interrupts: a new event beats a same-cycle clear
  always_comb begin
    irq_set = '0;
    irq_set[`CSB_IRQ_XFER_BIT]    = xfer;
    irq_set[`CSB_IRQ_BLOCKED_BIT] = blocked;
    irq_clr = (wr_commit && reg_idx == `CSB_IDX_IRQ_STATUS)
              ? avs_writedata[`CSB_IRQ_W-1:0] : '0;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      irq_stat_r <= '0;
      irq        <= 1'b0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;   // RULE8
      irq        <= |(irq_stat_r & irq_mask_r);          // RULE8
    end
  end

  // ==========================================================
  // Serial output
  csb_serout u_serout (
    .clk                   (clk),
    .srst                  (srst),
    .rx_in                 (rx_in),
    .hw_mode               (hw_mode),
    .clk_sel               (clk_sel_r),
    .output_frame_clock    (output_frame_clock),
    .auxiliary_frame_clock (auxiliary_frame_clock),
    .cs_serial_pin         (cs_serial_pin),
    .general_output_pin    (general_output_pin)
  );

  // ==========================================================
  // Checks
  host_copy_a: assert property (@(posedge clk) disable iff (srst) // RULE14
    xfer |=> (host_r[0][0] == $past(cap_r[0][0])) && (host_r[1][4] == $past(cap_r[1][4])))
    else $error("host buffer not copied whole on transfer");

  host_hold_a: assert property (@(posedge clk) disable iff (srst) // RULE2
    !xfer |=> $stable(host_r[0][0]) && $stable(host_r[1][0]))
    else $error("host buffer changed without a transfer");

  inhibit_stop_a: assert property (@(posedge clk) disable iff (srst) // RULE9
    inhibit_r |-> !xfer)
    else $error("transfer while inhibited");

  unlock_stop_a: assert property (@(posedge clk) disable iff (srst) // RULE6
    !rx_pll_lock |-> !xfer)
    else $error("transfer while out of lock");

  err_gate_a: assert property (@(posedge clk) disable iff (srst) // RULE7
    (cs_update_r && (err_acc_r != 4'h0)) |-> !xfer)
    else $error("transfer despite gated error");

  ungated_xfer_a: assert property (@(posedge clk) disable iff (srst) // RULE13
    (!cs_update_r && rx_in.block_start && blk_full && gap_ok && lock_ok && !inhibit_r)
    |-> xfer ##1 irq_stat_r[`CSB_IRQ_XFER_BIT])
    else $error("ungated block boundary did not transfer");

  xfer_gap_a: assert property (@(posedge clk) disable iff (srst) // RULE10
    xfer |=> !xfer [*8])
    else $error("transfers too close together");

  irq_raise_a: assert property (@(posedge clk) disable iff (srst) // RULE8
    (xfer && irq_mask_r[`CSB_IRQ_XFER_BIT]) |=> ##1 irq)
    else $error("transfer did not raise interrupt");

  msb_first_a: assert property (@(posedge clk) disable iff (srst) // RULE3
    (rx_in.valid && !rx_in.chan && bit_idx_r[0] == 8'h00) |=> cap_r[0][0][7] == $past(rx_in.cbit))
    else $error("first channel status bit not in byte msb");

  bus_answer_a: assert property (@(posedge clk) disable iff (srst) // RULE4
    (req && avs_waitrequest && bus_st_r == CSB_BUS_IDLE) |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus access not answered in one cycle");

  cs_read_a: assert property (@(posedge clk) disable iff (srst) // RULE1
    (bus_st_r == CSB_BUS_IDLE && avs_read && avs_address == 8'h8c && !xfer)
    |=> avs_readdata[7:0] == host_r[0][0])
    else $error("channel status byte read mismatch");

  lock_gate_a: assert property (@(posedge clk) disable iff (srst) // RULE6
    lock_lost_r |-> !xfer)
    else $error("transfer after lock slipped within block");

  blocked_flag_a: assert property (@(posedge clk) disable iff (srst) // RULE9
    blocked |=> irq_stat_r[`CSB_IRQ_BLOCKED_BIT])
    else $error("blocked transfer not flagged");

  irq_level_a: assert property (@(posedge clk) disable iff (srst) // RULE8
    irq == $past(|(irq_stat_r & irq_mask_r)))
    else $error("interrupt level does not follow masked status");

  status_clear_a: assert property (@(posedge clk) disable iff (srst) // RULE8
    (wr_commit && reg_idx == `CSB_IDX_IRQ_STATUS && avs_writedata[`CSB_IRQ_XFER_BIT] && !xfer)
    |=> !irq_stat_r[`CSB_IRQ_XFER_BIT])
    else $error("transfer flag not cleared by write of one");

  upper_zero_a: assert property (@(posedge clk) disable iff (srst) // RULE4
    !avs_waitrequest |-> avs_readdata[31:8] == 24'h000000)
    else $error("read data upper bytes not zero");

  odd_read_a: assert property (@(posedge clk) disable iff (srst) // RULE4
    (bus_st_r == CSB_BUS_IDLE && avs_read && avs_address[1:0] != 2'b00)
    |=> avs_readdata == 32'h0000_0000)
    else $error("misaligned read returned data");

  // Covers for the transfer, for each blocking cause the bench drives except the short gap, and for an interrupt clear
  inhibit_block_c: cover property (@(posedge clk) disable iff (srst) blocked && inhibit_r);
  lock_block_c:    cover property (@(posedge clk) disable iff (srst) blocked && lock_lost_r);
  xfer_seen_c:    cover property (@(posedge clk) disable iff (srst) xfer);
  blocked_seen_c: cover property (@(posedge clk) disable iff (srst) blocked && cs_update_r);
  irq_clear_c:    cover property (@(posedge clk) disable iff (srst) irq ##[1:20] !irq);

endmodule

`default_nettype wire

// ---- dv/csb_rx_model.sv ----
// Receiver model: sends one channel status block per go pulse.
// Assumes go is pulsed only while busy is low; frames counts A/B pairs.
`timescale 1ns/1ps
`default_nettype none

module csb_rx_model
  import csb_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        go,
  input  wire logic [7:0]  frames,
  input  wire logic [39:0] pat_a,
  input  wire logic [39:0] pat_b,
  output var  csb_rx_t     rx,
  output logic             busy
);
  logic [8:0]  cnt_r;
  logic [39:0] a_r;
  logic [39:0] b_r;

  // ==========================================================
  // Bit stream
  always_ff @(posedge clk) begin
    rx.valid       <= 1'b0;
    rx.block_start <= 1'b0;
    rx.cbit        <= ~rx.cbit;  // Idle line never keeps the last bit
    if (srst) begin
      rx.cbit <= 1'b0;
      rx.chan <= 1'b0;
      cnt_r   <= '0;
      busy    <= 1'b0;
    end else if (go && !busy) begin
      rx.block_start <= 1'b1;
      cnt_r          <= {frames, 1'b0};
      a_r            <= pat_a;
      b_r            <= pat_b;
      busy           <= 1'b1;
    end else if (cnt_r != '0) begin
      // A on even counts, B on odd; patterns wrap after 40 bits
      rx.valid <= 1'b1;
      rx.chan  <= cnt_r[0];
      rx.cbit  <= cnt_r[0] ? b_r[39] : a_r[39];
      if (cnt_r[0]) begin
        a_r <= {a_r[38:0], a_r[39]};
        b_r <= {b_r[38:0], b_r[39]};
      end
      cnt_r <= cnt_r - 9'h001;
    end else begin
      busy <= 1'b0;
    end
  end
endmodule

`default_nettype wire

// ---- dv/channel_status_buffer_tb.sv ----
// Testbench: blocks from the receiver model, host buffer read over Avalon-MM.
// Assumes short block and gap counts set below; expectations derive from them.
`timescale 1ns/1ps
`default_nettype none

module channel_status_buffer_tb
  import csb_pkg::*;
;
  localparam int BF = 48;
  localparam int GF = 60;
  logic        clk                   = 1'b0;
  logic        srst                  = 1'b1;
  logic [7:0]  avs_address           = 8'h00;
  logic        avs_read              = 1'b0;
  logic        avs_write             = 1'b0;
  logic [31:0] avs_writedata         = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  csb_rx_t     rx_in;
  csb_err_t    rx_err                = '0;
  logic        rx_pll_lock           = 1'b1;
  logic        hw_mode               = 1'b1;
  logic        output_frame_clock    = 1'b0;
  logic        auxiliary_frame_clock = 1'b0;
  logic        cs_serial_pin;
  logic        general_output_pin;
  logic        irq;
  logic        go                    = 1'b0;
  logic        busy;
  logic [7:0]  frames                = 8'h00;
  logic [39:0] pa                    = '0;
  logic [39:0] pb                    = '0;
  int          checks                = 0;
  int          err_total             = 0;

  always #5 clk = ~clk;

  csb_top #(.BLOCK_FRAMES(BF), .MIN_GAP_FRAMES(GF)) uut (
    .clk(clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'h1),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rx_in(rx_in),
    .rx_err(rx_err), .rx_pll_lock(rx_pll_lock), .hw_mode(hw_mode),
    .output_frame_clock(output_frame_clock), .auxiliary_frame_clock(auxiliary_frame_clock),
    .cs_serial_pin(cs_serial_pin), .general_output_pin(general_output_pin), .irq(irq));

  csb_rx_model rxm (.clk(clk), .srst(srst), .go(go), .frames(frames), .pat_a(pa),
    .pat_b(pb), .rx(rx_in), .busy(busy));

  // ==========================================================
  // Helpers
  function automatic logic [39:0] pat(input int k);
    return 40'hc35a960fe1 ^ {5{8'(k * 37)}};
  endfunction

  task automatic finish_test();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    checks++;
    if (s !== x) begin
      $display("[FAIL] %s exp %h seen %h", nm, x, s);
      err_total++;
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    avs_address   <= a;
    avs_writedata <= {24'h0, d};
    avs_write     <= w;
    avs_read      <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      err_total++;
      finish_test();
    end
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    chk($sformatf("reg %h", a), q, x);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  // Starts block k; e = 1..4 pulses one error kind, 5 drops lock for a cycle
  task automatic blk(input int k, input int f, input int e);
    int n;
    n = 0;
    pa     <= pat(k);
    pb     <= ~pat(k);
    frames <= 8'(f);
    go     <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    do begin
      @(posedge clk);
      n++;
      if (n == 30 && e == 5) begin
        rx_pll_lock <= 1'b0;
      end else if (n == 30 && e > 0) begin
        rx_err <= csb_err_t'(4'(1 << (e - 1)));
      end else begin
        rx_pll_lock <= 1'b1;
        rx_err      <= '0;
      end
    end while (busy !== 1'b0 && n < 600);
    if (busy !== 1'b0) begin
      err_total++;
      finish_test();
    end
  endtask

  // Host buffer must hold block k; st is the expected event status
  task automatic see_buf(input int k, input logic [1:0] st);
    logic [39:0] a;
    a = pat(k);
    chk("irq", {31'h0, irq}, {31'h0, st != 2'b00});
    for (int b = 0; b < 5; b++) begin
      rd(8'h8c + 8'(4 * b), {24'h0, a[39 - 8 * b -: 8]});
      rd(8'ha0 + 8'(4 * b), {24'h0, ~a[39 - 8 * b -: 8]});
    end
    rd(8'hc4, {30'h0, st});
    wr(8'hc4, 8'h03);
  endtask

  // ==========================================================
  // Scenarios
  initial begin
    repeat (100000) @(posedge clk);
    err_total++;
    finish_test();
  end

  initial begin
    logic [39:0] p;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rd(8'h10, 32'h0);
    rd(8'h58, 32'h10);
    rd(8'hc8, 32'h0);
    wr(8'h11, 8'h01);
    rd(8'h10, 32'h0);
    rd(8'hfc, 32'h0);
    rd(8'h59, 32'h0);
    blk(0, 64, 0);
    blk(1, 64, 0);
    chk("masked irq", {31'h0, irq}, 32'h0);
    wr(8'hc8, 8'h03);
    rd(8'hc8, 32'h3);
    repeat (2) @(posedge clk);
    see_buf(0, 2'b01);
    wr(8'h10, 8'h01);
    blk(2, 64, 0);
    see_buf(0, 2'b10);
    wr(8'h10, 8'h00);
    blk(3, BF, 0);
    see_buf(2, 2'b01);
    blk(4, 64, 0);
    see_buf(2, 2'b10);
    blk(5, BF - 1, 0);
    see_buf(4, 2'b01);
    blk(6, 64, 5);
    see_buf(4, 2'b00);
    blk(7, 64, 1);
    see_buf(4, 2'b10);
    blk(8, 64, 0);
    see_buf(7, 2'b01);
    wr(8'h58, 8'h80);
    for (int e = 1; e <= 5; e++) begin
      blk(8 + e, 64, e % 5);
      see_buf(8, (e == 1) ? 2'b01 : 2'b10);
    end
    blk(14, 64, 0);
    see_buf(13, 2'b01);
    // Category code byte; the generation bit sits in its lowest place
    p = pat(13);
    rd(8'h90, {24'h0, p[31:24]});
    rd(8'h58, 32'h90);
    // Last frame of block 14 carried bit 16 of each pattern
    p = pat(14);
    for (int m = 0; m < 2; m++) begin
      hw_mode <= (m == 0);
      wr(8'h10, {6'h0, m[0], 1'b0});
      for (int e = 0; e < 2; e++) begin
        if (m == 0) begin
          output_frame_clock <= (e == 0);
        end else begin
          auxiliary_frame_clock <= (e == 0);
        end
        repeat (5) @(posedge clk);
        chk("serial", {31'h0, m ? general_output_pin : cs_serial_pin},
            {31'h0, p[16] ^ e[0]});
        chk("idle pin", {31'h0, m ? cs_serial_pin : general_output_pin}, 32'h0);
      end
    end
    finish_test();
  end
endmodule

`default_nettype wire
